// [core/ctp_timer_pair.sv]
// Two classic counter/timers behind an AXI4-Lite register slave.
// Assumes one system clock, synchronous reset and asynchronous event and gate pins.
// Contract
// - Each timer picks one of five count clocks via select bits and prescale.
// - Counter operation adds one per falling edge on the timer's event pin.
// - Events up to a quarter clock rate; source holds each level two cycles.
// - 13-bit mode: high byte eight upper bits, low byte bits 4..0 lower five.
// - 13-bit wrap from all ones sets overflow flag and may request interrupt.
// - Counter select one counts event pin edges; zero counts chosen internal clock.
// - Sysclk select one counts system clock; zero counts the prescaled clock.
// - Counts only while run set and gate off or gate input active.
// - Setting run keeps the count; software loads the start value first.
// - Second timer has its own gate and polarity, otherwise identical.
// - 16-bit mode uses both bytes with the same clocking, gating and overflow.
// - 8-bit reload: low wraps, flag set, low reloaded from unchanged high.
// - Interrupt request only while that timer's enable bit is set.
// - Each timer has its own two-bit mode field in the mode register.
// - Each overflow is exported as an event pulse for other peripherals.
`timescale 1ns/1ps
module ctp_timer_pair
    import ctp_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic          REF_CLK_I,
    input  wire logic          RST_I,
    input  wire logic          CE_I,
    input  wire logic [AW-1:0] S_AXI_AWADDR_I,
    input  wire logic          S_AXI_AWVALID_I,
    output logic               S_AXI_AWREADY_O,
    input  wire logic [31:0]   S_AXI_WDATA_I,
    input  wire logic [3:0]    S_AXI_WSTRB_I,
    input  wire logic          S_AXI_WVALID_I,
    output logic               S_AXI_WREADY_O,
    output logic [1:0]         S_AXI_BRESP_O,
    output logic               S_AXI_BVALID_O,
    input  wire logic          S_AXI_BREADY_I,
    input  wire logic [AW-1:0] S_AXI_ARADDR_I,
    input  wire logic          S_AXI_ARVALID_I,
    output logic               S_AXI_ARREADY_O,
    output logic [31:0]        S_AXI_RDATA_O,
    output logic [1:0]         S_AXI_RRESP_O,
    output logic               S_AXI_RVALID_O,
    input  wire logic          S_AXI_RREADY_I,
    input  wire logic          EVENT_PIN_A_I,
    input  wire logic          EVENT_PIN_B_I,
    input  wire logic          GATE_INPUT_A_I,
    input  wire logic          GATE_INPUT_B_I,
    input  wire logic [1:0]    IRQ_ACK_I,
    output logic               IRQ_O,
    output logic               TIMER_A_OVF_O,
    output logic               TIMER_B_OVF_O
);
`include "ctp_defines.svh"

    ctp_link_if lnk ();

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [1:0]    timer_run_r;
    logic [7:0]    timer_mode_reg_r;
    logic [3:0]    clock_control_reg_r;
    logic [1:0]    gate_polarity_r;
    logic [1:0]    irq_en_r;
    logic [1:0]    overflow_flag_r;
    logic [7:0]    count_low_r [2];
    logic [7:0]    count_high_r [2];
    logic [1:0]    ovf_nxt;
    logic [1:0]    ovf_r;
    logic [1:0]    cnt_en;
    logic          irq_r;

    logic          awready_r;
    logic          wready_r;
    logic          bvalid_r;
    logic [1:0]    bresp_r;
    logic          arready_r;
    logic          rvalid_r;
    logic [1:0]    rresp_r;
    logic [31:0]   rdata_r;
    logic [AW-1:0] waddr_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;
    logic          wr_fire;
    logic [7:0]    wr_off;
    logic [7:0]    rd_off;
    logic [31:0]   rd_data;
    logic          rd_hit;
    logic          wr_hit;

    assign lnk.ce           = CE_I;
    assign lnk.prescale_sel = clock_control_reg_r[`CTP_CLK_PRE_LSB +: 2];
    assign lnk.pins_raw     = {GATE_INPUT_B_I, GATE_INPUT_A_I, EVENT_PIN_B_I, EVENT_PIN_A_I};

    ctp_prescale u_prescale (
        .REF_CLK_I (REF_CLK_I),
        .RST_I     (RST_I),
        .lnk       (lnk)
    );
    ctp_pin_sync #(.W(4)) u_pin_sync (
        .REF_CLK_I (REF_CLK_I),
        .RST_I     (RST_I),
        .lnk       (lnk)
    );
    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    // Address and data are parked until both have arrived, in either order.
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign wr_off  = 8'(waddr_r) & 8'hFC;
    assign wr_hit  = (wr_off <= `CTP_OFF_CNTB);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CTP_RESP_OKAY;
            waddr_r   <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end else if (CE_I) begin
            if (awready_r && S_AXI_AWVALID_I) begin
                awready_r <= 1'b0;
                waddr_r   <= S_AXI_AWADDR_I;
            end
            if (wready_r && S_AXI_WVALID_I) begin
                wready_r <= 1'b0;
                wdata_r  <= S_AXI_WDATA_I;
                wstrb_r  <= S_AXI_WSTRB_I;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? `CTP_RESP_OKAY : `CTP_RESP_SLVERR;
            end
            if (bvalid_r && S_AXI_BREADY_I) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    assign rd_off = 8'(S_AXI_ARADDR_I) & 8'hFC;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (rd_off)
            `CTP_OFF_RUN:  rd_data[1:0] = timer_run_r;
            `CTP_OFF_MODE: rd_data[7:0] = timer_mode_reg_r;
            `CTP_OFF_CLK:  rd_data[3:0] = clock_control_reg_r;
            `CTP_OFF_POL:  rd_data[1:0] = gate_polarity_r;
            `CTP_OFF_IEN:  rd_data[1:0] = irq_en_r;
            `CTP_OFF_STAT: rd_data[1:0] = overflow_flag_r;
            `CTP_OFF_CNTA: rd_data[15:0] = {count_high_r[0], count_low_r[0]};
            `CTP_OFF_CNTB: rd_data[15:0] = {count_high_r[1], count_low_r[1]};
            default:       rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= `CTP_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else if (CE_I) begin
            if (arready_r && S_AXI_ARVALID_I) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_data;
                rresp_r   <= rd_hit ? `CTP_RESP_OKAY : `CTP_RESP_SLVERR;
            end else if (rvalid_r && S_AXI_RREADY_I) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // separate mode fields
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            timer_run_r         <= `CTP_RST_PAIR;
            timer_mode_reg_r    <= `CTP_RST_BYTE;
            clock_control_reg_r <= 4'h0;
            gate_polarity_r     <= `CTP_RST_PAIR;
            irq_en_r            <= `CTP_RST_PAIR;
        end else if (CE_I && wr_fire && wstrb_r[0]) begin
            unique case (wr_off)
                `CTP_OFF_RUN:  timer_run_r         <= wdata_r[1:0];
                `CTP_OFF_MODE: timer_mode_reg_r    <= wdata_r[7:0];
                `CTP_OFF_CLK:  clock_control_reg_r <= wdata_r[3:0];
                `CTP_OFF_POL:  gate_polarity_r     <= wdata_r[1:0];
                `CTP_OFF_IEN:  irq_en_r            <= wdata_r[1:0];
                default:       ;
            endcase
        end
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    // identical second timer
    for (genvar i = 0; i < 2; i++) begin : g_timer
        logic [3:0]   fld;
        ctp_mode_type mode;
        logic         src_tick;
        logic         gate_act;
        logic         wr_cnt;
        logic [7:0]   cnt_off;
        assign fld     = timer_mode_reg_r[i*`CTP_MODE_B_LSB +: 4];
        assign mode    = ctp_mode_type'(fld[1:0]);
        assign cnt_off = (i == 0) ? `CTP_OFF_CNTA : `CTP_OFF_CNTB;
        assign wr_cnt  = wr_fire && (wr_off == cnt_off);
        assign src_tick = fld[`CTP_MODE_CSEL] ? lnk.pins_fall[i] :
                          clock_control_reg_r[`CTP_CLK_SYS_LSB + i] ? 1'b1 :
                          lnk.prescale_tick;
        assign gate_act  = lnk.pins_level[2 + i] ~^ gate_polarity_r[i];
        // Split mode is not built, so a timer set to it simply holds its count.
        assign cnt_en[i] = timer_run_r[i] && (!fld[`CTP_MODE_GATE] || gate_act)
                           && src_tick && (mode != CTP_MODE_SPLIT) && !wr_cnt;
        always_comb begin
            ovf_nxt[i] = 1'b0;
            if (cnt_en[i]) begin
                unique case (mode)
                    CTP_MODE_13BIT:   ovf_nxt[i] = (count_high_r[i] == 8'hFF)
                                                   && (count_low_r[i][4:0] == 5'h1F);
                    CTP_MODE_16BIT:   ovf_nxt[i] = ({count_high_r[i], count_low_r[i]}
                                                   == 16'hFFFF);
                    CTP_MODE_8RELOAD: ovf_nxt[i] = (count_low_r[i] == 8'hFF);
                    CTP_MODE_SPLIT:   ovf_nxt[i] = 1'b0;
                endcase
            end
        end
        always_ff @(posedge REF_CLK_I) begin
            if (RST_I) begin
                count_low_r[i]  <= `CTP_RST_BYTE;
                count_high_r[i] <= `CTP_RST_BYTE;
            end else if (CE_I) begin
                if (wr_cnt) begin
                    if (wstrb_r[0]) begin
                        count_low_r[i] <= wdata_r[7:0];
                    end
                    if (wstrb_r[1]) begin
                        count_high_r[i] <= wdata_r[15:8];
                    end
                end else if (cnt_en[i]) begin
                    unique case (mode)
                        CTP_MODE_13BIT: begin
                            count_low_r[i][4:0] <= count_low_r[i][4:0] + 5'h01;
                            if (count_low_r[i][4:0] == 5'h1F) begin
                                count_high_r[i] <= count_high_r[i] + 8'h01;
                            end
                        end
                        CTP_MODE_16BIT: begin
                            {count_high_r[i], count_low_r[i]} <=
                                {count_high_r[i], count_low_r[i]} + 16'h0001;
                        end
                        CTP_MODE_8RELOAD: begin
                            count_low_r[i] <= ovf_nxt[i] ? count_high_r[i]
                                                         : count_low_r[i] + 8'h01;
                        end
                        CTP_MODE_SPLIT: ;
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Flags, interrupt and overflow events
    // ****************************************************************
    // set beats clear
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            overflow_flag_r <= `CTP_RST_PAIR;
        end else if (CE_I) begin
            overflow_flag_r <= (overflow_flag_r
                                & ~((wr_fire && wstrb_r[0] && wr_off == `CTP_OFF_STAT)
                                    ? wdata_r[1:0] : 2'h0)
                                & ~IRQ_ACK_I)
                               | ovf_nxt;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            irq_r <= 1'b0;
            ovf_r <= `CTP_RST_PAIR;
        end else if (CE_I) begin
            irq_r <= |(overflow_flag_r & irq_en_r);
            ovf_r <= ovf_nxt;
        end
    end

    assign IRQ_O           = irq_r;
    assign TIMER_A_OVF_O   = ovf_r[0];
    assign TIMER_B_OVF_O   = ovf_r[1];
    assign S_AXI_AWREADY_O = awready_r;
    assign S_AXI_WREADY_O  = wready_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    assign S_AXI_ARREADY_O = arready_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RRESP_O   = rresp_r;
    assign S_AXI_RDATA_O   = rdata_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    irq_mask_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CE_I |=> IRQ_O == |($past(overflow_flag_r) & $past(irq_en_r)))
        else $error("Interrupt does not follow masked flags.");
    flag_set_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CE_I && ovf_nxt[0] |=> overflow_flag_r[0] && TIMER_A_OVF_O)
        else $error("Overflow did not set flag and event.");
    stop_hold_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CE_I && !timer_run_r[1] && !wr_fire |=> $stable(count_low_r[1])
        && $stable(count_high_r[1]))
        else $error("Stopped timer changed its count.");
    inc16_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CE_I && cnt_en[0] && timer_mode_reg_r[1:0] == 2'h1
        |=> {count_high_r[0], count_low_r[0]}
            == {$past(count_high_r[0]), $past(count_low_r[0])} + 16'h0001)
        else $error("16-bit count did not step by one.");
    reload8_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CE_I && cnt_en[0] && timer_mode_reg_r[1:0] == 2'h2 && count_low_r[0] == 8'hFF
        |=> count_low_r[0] == $past(count_high_r[0]) && $stable(count_high_r[0])
            && overflow_flag_r[0])
        else $error("Reload mode did not reload from high byte.");
    wrap13_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        CE_I && cnt_en[1] && timer_mode_reg_r[5:4] == 2'h0
        && count_high_r[1] == 8'hFF && count_low_r[1][4:0] == 5'h1F
        |=> count_high_r[1] == 8'h00 && count_low_r[1][4:0] == 5'h00 && TIMER_B_OVF_O)
        else $error("13-bit wrap misbehaved.");
    gate_off_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        timer_mode_reg_r[`CTP_MODE_GATE] && !(lnk.pins_level[2] ~^ gate_polarity_r[0])
        |-> !cnt_en[0])
        else $error("Gated timer counted with gate inactive.");
    bresp_hold_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("Write answer dropped before it was taken.");

endmodule

// [core/ctp_defines.svh]
// Offsets, field positions, reset values and prescale counts of the timer pair.
// Assumes byte addresses on a 32-bit AXI4-Lite register bus, one word per register.
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CTP_OFF_RUN     8'h00
`define CTP_OFF_MODE    8'h04
`define CTP_OFF_CLK     8'h08
`define CTP_OFF_POL     8'h0C
`define CTP_OFF_IEN     8'h10
`define CTP_OFF_STAT    8'h14
`define CTP_OFF_CNTA    8'h18
`define CTP_OFF_CNTB    8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define CTP_MODE_B_LSB  4
`define CTP_MODE_CSEL   2
`define CTP_MODE_GATE   3
`define CTP_CLK_PRE_LSB 0
`define CTP_CLK_SYS_LSB 2

// ****************************************************************
// Reset values
// ****************************************************************
`define CTP_RST_BYTE    8'h00
`define CTP_RST_PAIR    2'h0

// ****************************************************************
// Prescale divide ratios, one per prescale field value
// ****************************************************************
`define CTP_PRE_DIV0    8'h0C
`define CTP_PRE_DIV1    8'h04
`define CTP_PRE_DIV2    8'h30
`define CTP_PRE_DIV3    8'h08

// ****************************************************************
// Bus answers
// ****************************************************************
`define CTP_RESP_OKAY   2'h0
`define CTP_RESP_SLVERR 2'h2

`endif

// [core/ctp_pkg.sv]
// Types shared by the timer pair modules.
// Assumes nothing of its surroundings.
package ctp_pkg;

    typedef enum logic [1:0] {
        CTP_MODE_13BIT,
        CTP_MODE_16BIT,
        CTP_MODE_8RELOAD,
        CTP_MODE_SPLIT
    } ctp_mode_type;

endpackage

// [core/ctp_link_if.sv]
// Carrier between the timer core, its prescaler and its pin synchroniser.
// Assumes all members but pins_raw live on the one system clock.
`timescale 1ns/1ps
interface ctp_link_if;
    logic       ce;
    logic [1:0] prescale_sel;
    logic       prescale_tick;
    logic [3:0] pins_raw;
    logic [3:0] pins_level;
    logic [3:0] pins_fall;

    modport core  (output ce, prescale_sel, pins_raw,
                   input  prescale_tick, pins_level, pins_fall);
    modport presc (input ce, prescale_sel, output prescale_tick);
    modport sync  (input ce, pins_raw, output pins_level, pins_fall);
endinterface

// [core/ctp_prescale.sv]
// Prescaled count enable for the timer pair.
// Assumes the clock enable and the divide select come over the link interface.
`timescale 1ns/1ps
module ctp_prescale
    import ctp_pkg::*;
(
    input  wire logic REF_CLK_I,
    input  wire logic RST_I,
    ctp_link_if.presc lnk
);
`include "ctp_defines.svh"

    logic [7:0] div_cnt_r;
    logic [7:0] div_top;
    logic       tick_r;

    // ****************************************************************
    // Divider
    // ****************************************************************
    always_comb begin
        unique case (lnk.prescale_sel)
            2'h0: div_top = `CTP_PRE_DIV0 - 8'h01;
            2'h1: div_top = `CTP_PRE_DIV1 - 8'h01;
            2'h2: div_top = `CTP_PRE_DIV2 - 8'h01;
            2'h3: div_top = `CTP_PRE_DIV3 - 8'h01;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            div_cnt_r <= `CTP_RST_BYTE;
            tick_r    <= 1'b0;
        end else if (lnk.ce) begin
            if (div_cnt_r >= div_top) begin
                div_cnt_r <= `CTP_RST_BYTE;
                tick_r    <= 1'b1;
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
                tick_r    <= 1'b0;
            end
        end
    end

    assign lnk.prescale_tick = tick_r;

    prescale_pulse_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        lnk.ce && tick_r |=> !tick_r)
        else $error("Prescale tick lasted more than one cycle.");

endmodule

// [core/ctp_pin_sync.sv]
// Three-stage synchroniser with agreement filter and falling edge detect.
// Assumes raw inputs are asynchronous to the system clock.
`timescale 1ns/1ps
module ctp_pin_sync
    import ctp_pkg::*;
#(
    parameter int W = 4
) (
    input  wire logic REF_CLK_I,
    input  wire logic RST_I,
    ctp_link_if.sync  lnk
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] fall_r;

    // ****************************************************************
    // Synchroniser and filter
    // ****************************************************************
    // sampled level filter
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            s1_r    <= '0;
            s2_r    <= '0;
            s3_r    <= '0;
            level_r <= '0;
            fall_r  <= '0;
        end else if (lnk.ce) begin
            s1_r    <= lnk.pins_raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            // A level is taken only once two stages agree, so a one-sample glitch never counts.
            level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
            fall_r  <= level_r & ~((s2_r & s3_r) | (level_r & (s2_r | s3_r)));
        end
    end

    assign lnk.pins_level = level_r;
    assign lnk.pins_fall  = fall_r;

    fall_once_a : assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        lnk.ce && (fall_r != '0) |=> ((fall_r & $past(fall_r)) == '0))
        else $error("One falling edge gave two count pulses.");

endmodule

// [test/ctp_pin_model.sv]
// Far-side model of the event pin and gate source of the timer pair.
// Assumes the bench system clock; the event pin idles high between bursts.
`timescale 1ns/1ps
module ctp_pin_model (
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic       gate_i,
    output logic            evt_o,
    output logic            gate_o,
    output logic [7:0]      falls_o
);
    logic [1:0] ph_r = 2'h0;
    logic       evt_q = 1'b1;
    logic [7:0] cnt_r = 8'h00;
    assign evt_o = run_i ? ~ph_r[1] : 1'b1;
    assign gate_o = gate_i;
    assign falls_o = cnt_r;
    always_ff @(posedge clk_i) begin
        ph_r <= run_i ? ph_r + 2'h1 : 2'h0;
        evt_q <= evt_o;
        if (evt_q && !evt_o) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule

// [test/tb_top.sv]
// Self-checking bench of the timer pair over its register bus and pins.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import ctp_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
    logic        arv = 1'b0, rr = 1'b0, pr = 1'b0, gl = 1'b0;
    logic [7:0]  aw = 8'h00, ar = 8'h00, fl;
    logic [31:0] wd = 32'h0, rdata, d;
    logic [1:0]  bresp, rresp, r, wb, ack = 2'h0;
    logic        awr, wr, bv, arr, rv, irq, ova, ovb, evt, gate;
    int          err_count = 0;
    int          n_tests = 0;
    always #5 clk = ~clk;
    ctp_pin_model PM (.clk_i(clk), .run_i(pr), .gate_i(gl), .evt_o(evt), .gate_o(gate),
        .falls_o(fl));
    ctp_timer_pair DUT (.REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
        .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
        .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rr), .EVENT_PIN_A_I(evt), .EVENT_PIN_B_I(evt),
        .GATE_INPUT_A_I(gate), .GATE_INPUT_B_I(gate), .IRQ_ACK_I(ack),
        .IRQ_O(irq), .TIMER_A_OVF_O(ova), .TIMER_B_OVF_O(ovb));
    task automatic summarize;
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Handshake levels are sampled at the falling edge, so the take edge is race free.
    task automatic wreg(input logic [7:0] a, input logic [31:0] dat);
        logic ta, tw, tb;
        int n;
        @(posedge clk);
        aw <= a; wd <= dat; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ta = awr; tw = wr; tb = bv;
            wb = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) break;
        end
        br <= 1'b0;
        if (n == 50) begin err_count++; summarize(); end
    endtask
    task automatic rreg(input logic [7:0] a);
        logic ta, tv;
        int n;
        @(posedge clk);
        ar <= a; arv <= 1'b1; rr <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            ta = arr; tv = rv; d = rdata; r = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tv) break;
        end
        rr <= 1'b0;
        if (n == 50) begin err_count++; summarize(); end
    endtask
    task automatic t_reload;
        int n;
        wreg(8'h18, 32'h0000F0FE);
        wreg(8'h04, 32'(CTP_MODE_8RELOAD));
        wreg(8'h08, 32'h4);
        wreg(8'h00, 32'h1);
        for (n = 0; n < 20 && ova !== 1'b1; n++) @(negedge clk);
        check(ova, 1'b1, "ovf a");
        check(irq, 1'b0, "irq masked");
        rreg(8'h14);
        check(d, 32'h1, "flag a");
        wreg(8'h10, 32'h1);
        repeat (3) @(negedge clk);
        check(irq, 1'b1, "irq on");
        wreg(8'h00, 32'h0);
        rreg(8'h18);
        check(d[15:8], 8'hF0, "reload high");
        check(d[7:0] >= 8'hF0, 1'b1, "reload low");
        wreg(8'h14, 32'h1);
        repeat (3) @(negedge clk);
        check(irq, 1'b0, "irq clear");
    endtask
    task automatic t_count;
        logic [7:0] f0;
        wreg(8'h04, 32'hD0);
        wreg(8'h0C, 32'h2);
        wreg(8'h1C, 32'h00FF);
        wreg(8'h00, 32'h2);
        pr <= 1'b1;
        repeat (40) @(posedge clk);
        pr <= 1'b0;
        repeat (10) @(posedge clk);
        rreg(8'h1C);
        check(d, 32'h00FF, "gated off");
        gl <= 1'b1;
        repeat (10) @(posedge clk);
        f0 = fl;
        pr <= 1'b1;
        repeat (40) @(posedge clk);
        pr <= 1'b0;
        repeat (10) @(posedge clk);
        rreg(8'h1C);
        check(d, 32'h00FF + 32'(fl - f0), "event count");
    endtask
    task automatic t_wrap;
        int n;
        wreg(8'h00, 32'h0);
        wreg(8'h04, 32'h0);
        wreg(8'h08, 32'h8);
        wreg(8'h1C, 32'h0000FFFE);
        wreg(8'h00, 32'h2);
        for (n = 0; n < 20 && ovb !== 1'b1; n++) @(negedge clk);
        check(ovb, 1'b1, "ovf b");
        wreg(8'h00, 32'h0);
        rreg(8'h1C);
        check(d[15:5], 11'h007, "wrap 13");
        rreg(8'h14);
        check(d, 32'h2, "flag b");
        check(irq, 1'b0, "irq b masked");
        @(posedge clk);
        ack <= 2'h2;
        @(posedge clk);
        ack <= 2'h0;
        rreg(8'h14);
        check(d, 32'h0, "ack clear");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rreg(8'h18);
        check(d, 32'h0, "count reset");
        rreg(8'h20);
        check(r, 2'h2, "unmapped resp");
        check(d, 32'h0, "unmapped data");
        wreg(8'h20, 32'h1);
        check(wb, 2'h2, "unmapped wr resp");
        t_reload();
        t_count();
        t_wrap();
        summarize();
    end
endmodule
